// *** hdl/dsfr_receiver.sv ***
// Three-wire serial frame receiver of a quad DAC: frame sync, serial clock, data.
// Assumes the serial pins are asynchronous and much slower than clk; the
// downstream consumer drains words through a valid/ready stream.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - One shift register of exactly sixteen bits collects each written word.
// - Data is sampled on falling serial clock edges only, never on rising ones.
// - Frame sync going low opens a frame and the next sixteen falling edges carry data.
// - Frame sync rising before the sixteenth falling edge aborts and drops the partial word.
// - After a finished word the inputs are ignored until the frame closes and a new one opens.
module dsfr_receiver
  import dsfr_pkg::*;
#(
  parameter int WIDTH = WORD_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             sync_n,
  input  wire logic             sclk,
  input  wire logic             sdin,
  output logic                  word_valid,
  output logic      [WIDTH-1:0] word_data,
  output logic                  frame_active,
  output logic                  frame_abort,
  output logic                  inputs_powered,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  overflow
);
  // Two-flop synchronisers; stage one is read only by stage two
  logic [2:0] sync_s1;
  logic [2:0] sync_s2;
  logic       sync_n_q;
  logic       sclk_q;
  logic       sdin_q;
  logic       sclk_prev;
  logic       sync_prev;
  logic       sclk_fall;
  logic       sync_fall;
  logic       sync_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle pin levels, so no false serial clock edge follows reset
      sync_s1 <= PIN_IDLE;
      sync_s2 <= PIN_IDLE;
    end else begin
      sync_s1 <= {sync_n, sclk, sdin};
      sync_s2 <= sync_s1;
    end
  end
  assign sync_n_q = sync_s2[2];
  assign sclk_q   = sync_s2[1];
  assign sdin_q   = sync_s2[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev <= 1'b1;
      sync_prev <= 1'b1;
    end else begin
      sclk_prev <= sclk_q;
      sync_prev <= sync_n_q;
    end
  end
  // Sampling a 30 MHz serial clock with a 10 MHz clock cannot see every
  // edge; the link must run below clk/4 for this receiver to be exact.
  assign sclk_fall = sclk_prev && !sclk_q;
  assign sync_fall = sync_prev && !sync_n_q;
  assign sync_rise = !sync_prev && sync_n_q;

  dsfr_state_t        state;
  logic [WIDTH-1:0]   shreg;
  logic [CNT_BITS-1:0] bit_cnt;
  logic               fifo_in_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DSFR_IDLE;
    end else begin
      unique case (state)
        DSFR_IDLE: begin
          if (sync_fall) begin
            state <= DSFR_SHIFT;
          end
        end
        DSFR_SHIFT: begin
          if (sync_rise) begin
            state <= DSFR_IDLE;
          end else if (sclk_fall && bit_cnt == CNT_FULL - 5'h01) begin
            state <= DSFR_DONE;
          end
        end
        DSFR_DONE: begin
          if (sync_rise || sync_n_q) begin
            state <= DSFR_IDLE;
          end
        end
        default: state <= DSFR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg   <= SHIFT_RST;
      bit_cnt <= CNT_RST;
    end else if (state == DSFR_IDLE) begin
      bit_cnt <= CNT_RST;
    end else if (state == DSFR_SHIFT && !sync_rise && sclk_fall) begin
      shreg   <= {shreg[WIDTH-2:0], sdin_q};
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_valid  <= 1'b0;
      word_data   <= SHIFT_RST;
      frame_abort <= 1'b0;
    end else begin
      word_valid  <= 1'b0;
      frame_abort <= state == DSFR_SHIFT && sync_rise;
      if (state == DSFR_SHIFT && !sync_rise && sclk_fall && bit_cnt == CNT_FULL - 5'h01) begin
        word_valid <= 1'b1;
        word_data  <= {shreg[WIDTH-2:0], sdin_q};
      end
    end
  end

  // Words that find the FIFO full are dropped and flagged, since the link
  // has no way to stall the controller.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow <= 1'b0;
    end else begin
      overflow <= word_valid && !fifo_in_ready;
    end
  end

  assign frame_active   = state == DSFR_SHIFT;
  assign inputs_powered = state == DSFR_SHIFT;

  dsfr_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (word_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (word_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );
endmodule
`default_nettype wire

// *** hdl/dsfr_pkg.sv ***
// Package for the serial frame receiver: word size, FIFO depth, link timing.
// Assumes a 10 MHz system clock that samples the serial pins.
package dsfr_pkg;
  localparam int WORD_BITS    = 16;
  localparam int FIFO_DEPTH   = 16;
  localparam int CNT_BITS     = 5;
  localparam int CLK_HZ       = 10_000_000;
  localparam int SCLK_MAX_HZ  = 30_000_000;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [4:0]  CNT_RST   = 5'h00;
  localparam logic [4:0]  CNT_FULL  = 5'h10;
  localparam logic [2:0]  PIN_IDLE  = 3'h6;  // {sync_n, sclk, sdin} at rest
  typedef enum logic [1:0] {
    DSFR_IDLE  = 2'b00,
    DSFR_SHIFT = 2'b01,
    DSFR_DONE  = 2'b11
  } dsfr_state_t;
endpackage

// *** hdl/dsfr_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module dsfr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/dsfr_sva.sv ***
// Port checker for the serial frame receiver.
// Assumes it is bound onto dsfr_receiver.
`timescale 1ns/10ps
`default_nettype none
module dsfr_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        sync_n,
  input wire logic        word_valid,
  input wire logic [15:0] word_data,
  input wire logic        frame_active,
  input wire logic        frame_abort,
  input wire logic        inputs_powered,
  input wire logic        out_valid,
  input wire logic        overflow
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_word_pulse: assert property (word_valid |=> !word_valid)
    else $error("word pulse too long");
  a_word_held: assert property (!word_valid |-> $stable(word_data))
    else $error("word changed without pulse");
  a_abort_empty: assert property (frame_abort |-> !word_valid && !frame_active)
    else $error("word on abort");
  a_power_follow: assert property ((word_valid || !frame_active) |-> !inputs_powered)
    else $error("inputs powered outside a frame");
  a_idle_closed: assert property (sync_n [*4] |-> !frame_active)
    else $error("frame open while idle");
  a_word_framed: assert property ($rose(word_valid) |-> $past(frame_active))
    else $error("word outside frame");
  a_drop_full: assert property (overflow |-> out_valid)
    else $error("drop while not full");
  c_word: cover property (word_valid);
  c_abort: cover property (frame_abort);
  c_drop: cover property (overflow);
endmodule
bind dsfr_receiver dsfr_chk u_chk (
  .clk            (clk),
  .rst_n          (rst_n),
  .sync_n         (sync_n),
  .word_valid     (word_valid),
  .word_data      (word_data),
  .frame_active   (frame_active),
  .frame_abort    (frame_abort),
  .inputs_powered (inputs_powered),
  .out_valid      (out_valid),
  .overflow       (overflow)
);
`default_nettype wire

// *** verif/dsfr_host.sv ***
// Controller model driving frames on the three serial pins.
// Assumes the receiver samples the pins with its own clock.
`timescale 1ns/10ps
`default_nettype none
module dsfr_host (
  output var logic sync_n,
  output var logic sclk,
  output var logic sdin
);
  initial begin
    sync_n = 1'b1;
    sclk   = 1'b1;
    sdin   = 1'b0;
  end
  // Fewer than 16 bits aborts; more adds edges that must be ignored
  // Called on a clk edge; pins move by non-blocking assignment so the
  // receiver's samplers never race them
  task automatic frame(input logic [15:0] w, input int n);
    sync_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      sdin <= (i < 16) ? w[15-i] : 1'b0;
      #400 sclk <= 1'b0;
      // Flip data while low so rising-edge sampling gets the wrong bit
      #200 sdin <= ~sdin;
      #200 sclk <= 1'b1;
    end
    #200 sync_n <= 1'b1;
    #600;
  endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the serial frame receiver.
// Assumes the host model drives the pins; the bench drives clock, reset, out_ready.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        out_ready = 1'b0;
  wire logic   sync_n, sclk, sdin;
  logic        wv, fabt, ov, ovf, fa, pw;
  logic [15:0] wd, od, lastw;
  int          n_fail = 0, num_checks = 0, nw = 0, na = 0, nov = 0, npw = 0;
  dsfr_host u_host (.sync_n(sync_n), .sclk(sclk), .sdin(sdin));
  dsfr_receiver DUT (.clk(clk), .rst_n(rst_n), .sync_n(sync_n), .sclk(sclk),
    .sdin(sdin), .word_valid(wv), .word_data(wd), .frame_active(fa),
    .frame_abort(fabt), .inputs_powered(pw), .out_valid(ov),
    .out_ready(out_ready), .out_data(od), .overflow(ovf));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    if (wv === 1'b1) begin
      nw++;
      lastw = wd;
    end
    if (fabt === 1'b1) na++;
    if (ovf === 1'b1) nov++;
    if (pw === 1'b1) npw++;
  end
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Powered cycles: sync fall seen after 3 edges, 16th shift 3 edges after its fall
  task automatic t_abort;
    npw = 0;
    u_host.frame(16'hFFFF, 9);
    chk("aborts", 16'h0001, 16'(na));
    chk("words", 16'h0001, 16'(nw));
    chk("powered", 16'h004A, 16'(npw));
  endtask
  task automatic t_extra;
    npw = 0;
    u_host.frame(16'h3C5A, 20);
    chk("words", 16'h0002, 16'(nw));
    chk("word", 16'h3C5A, lastw);
    chk("powered", 16'h007C, 16'(npw));
    chk("aborts", 16'h0001, 16'(na));
    chk("active", 16'h0000, 16'(fa));
  endtask
  // Consumer stalls until 17 words arrived, so one is dropped
  task automatic t_fifo;
    int k;
    for (k = 0; k < 15; k++) u_host.frame(16'(k), 16);
    chk("drops", 16'h0001, 16'(nov));
    @(posedge clk) out_ready <= 1'b1;
    k = 0;
    repeat (40) begin
      @(posedge clk);
      if (ov === 1'b1) begin
        if (k == 0) chk("head", 16'hA5C3, od);
        else chk("fifo word", (k == 1) ? 16'h3C5A : 16'(k - 2), od);
        k++;
      end
    end
    chk("drained", 16'h0010, 16'(k));
    chk("empty", 16'h0000, 16'(ov));
  endtask
  initial begin
    #3000000;
    n_fail++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    u_host.frame(16'hA5C3, 16);
    chk("words", 16'h0001, 16'(nw));
    chk("word", 16'hA5C3, lastw);
    chk("powered", 16'h007C, 16'(npw));
    chk("buffers", 16'h0000, 16'(pw));
    t_abort;
    t_extra;
    t_fifo;
    final_report;
  end
endmodule
`default_nettype wire
